// ===== hdl/token_host.sv
// Host-side controller for one port of a dual-port token-flag block.
// Assumes the device port pins are wired directly; data bus is two-way.
`timescale 1ns/10ps
`default_nettype none
`include "token_host_regs.svh"
// Functional notes
// - Tokens active low: zero claims, one releases
// - Flag select low, else SRAM-style access
// - Claim writes zero then reads back
// - Failed claim: poll again or withdraw
// - Deassert strobes between polling reads
// - Write one to all tokens after power-up
// - Memory chip enable high during access
module token_host
	import token_host_pkg::*;
(
	input  wire logic                    CLOCK,        // 200 MHz clock
	input  wire logic                    RST,          // Asynchronous reset, high
	input  wire logic                    CMD_VALID,    // Command request
	output logic                         CMD_READY,    // Idle, command accepted
	input  wire logic [1:0]              CMD_OP,       // host_cmd_t code
	input  wire logic [`TOKEN_IDX_W-1:0] CMD_TOKEN,    // Token number
	output logic                         RSP_VALID,    // One-cycle answer pulse
	output logic                         RSP_OWNED,    // Claim or poll saw zero
	output logic                         INIT_BUSY,    // Power-up release running
	output logic [`ADDR_W-1:0]           TOKEN_INDEX_ADDR, // Device address pins
	output logic                         CHIP_ENABLE_N, // Memory chip enable
	output logic                         FLAG_SPACE_SELECT_N, // Token space select
	output logic                         OUT_ENABLE_N,  // Output enable
	output logic                         READ_WRITE_N,  // High read, low write
	input  wire logic [`DATA_W-1:0]      DATA_IN,      // Data pins, input side
	output logic      [`DATA_W-1:0]      DATA_OUT,     // Data pins, driven value
	output logic                         DATA_OE       // High while driving data
);
	localparam int SETUP_CYC   = `ACCESS_SETUP_CYC;
	localparam int STROBE_CYC  = `STROBE_CYC;
	localparam int RECOVER_CYC = `RECOVER_CYC;

	host_state_t                 state_q, state_d;
	logic [3:0]                  cnt_q;
	logic [`TOKEN_IDX_W-1:0]     tok_q;
	logic                        is_write_q;
	logic                        wdata_q;
	logic                        read_after_q;
	logic                        init_q;
	logic                        owned_q;
	logic                        rsp_q;
	logic [`DATA_W-1:0]          data_sync;

	pin_sync #(.W(`DATA_W)) u_sync (
		.clk (CLOCK),
		.rst (RST),
		.d   (DATA_IN),
		.q   (data_sync)
	);

	wire cmd_take   = CMD_VALID && CMD_READY;
	wire cnt_done   = (cnt_q == 4'h0);
	wire last_token = (tok_q == `TOKEN_IDX_W'(`TOKEN_COUNT - 1));
	wire in_access  = (state_q == ST_SETUP) || (state_q == ST_STROBE);
	// Select and write data stay one cycle past the write strobe, so the
	// strobe edge that lands the write never races the select edge
	wire hold_cyc   = (state_q == ST_RECOVER) && !cnt_done;
	wire sel_active = in_access || hold_cyc;
	wire read_flag  = data_sync[`FLAG_BIT];

	assign CMD_READY           = (state_q == ST_IDLE) && !init_q;
	assign RSP_VALID           = rsp_q;
	assign RSP_OWNED           = owned_q;
	assign INIT_BUSY           = init_q;
	assign CHIP_ENABLE_N       = 1'b1;
	assign FLAG_SPACE_SELECT_N = !sel_active;
	assign OUT_ENABLE_N        = !(in_access && !is_write_q);
	assign READ_WRITE_N        = !((state_q == ST_STROBE) && is_write_q);
	assign DATA_OE             = sel_active && is_write_q;
	assign DATA_OUT            = {{(`DATA_W-1){1'b1}}, wdata_q};
	assign TOKEN_INDEX_ADDR    = {{(`ADDR_W-`TOKEN_IDX_W){1'b0}}, tok_q};

	always_comb begin
		state_d = state_q;
		unique case (state_q)
			ST_IDLE: begin
				if (cmd_take || init_q) begin
					state_d = ST_SETUP;
				end
			end
			ST_SETUP: begin
				if (cnt_done) begin
					state_d = ST_STROBE;
				end
			end
			ST_STROBE: begin
				if (cnt_done) begin
					state_d = ST_RECOVER;
				end
			end
			ST_RECOVER: begin
				if (cnt_done) begin
					state_d = ST_DONE;
				end
			end
			ST_DONE: begin
				if (read_after_q && !init_q) begin
					state_d = ST_SETUP;
				end else begin
					state_d = ST_IDLE;
				end
			end
		endcase
	end

	always_ff @(posedge CLOCK or posedge RST) begin
		if (RST) begin
			state_q      <= ST_IDLE;
			cnt_q        <= 4'h0;
			tok_q        <= '0;
			is_write_q   <= 1'b0;
			wdata_q      <= 1'b1;
			read_after_q <= 1'b0;
			init_q       <= 1'b1;
			owned_q      <= 1'b0;
			rsp_q        <= 1'b0;
		end else begin
			state_q <= state_d;
			rsp_q   <= 1'b0;
			unique case (state_q)
				ST_IDLE: begin
					cnt_q <= 4'(SETUP_CYC - 1);
					if (init_q) begin
						is_write_q   <= 1'b1;
						wdata_q      <= 1'b1;
						read_after_q <= 1'b0;
					end else if (cmd_take) begin
						tok_q        <= CMD_TOKEN;
						is_write_q   <= (CMD_OP != 2'(CMD_POLL));
						wdata_q      <= (CMD_OP != 2'(CMD_CLAIM));
						read_after_q <= (CMD_OP == 2'(CMD_CLAIM));
					end
				end
				ST_SETUP: begin
					if (cnt_done) begin
						cnt_q <= 4'(STROBE_CYC - 1);
					end else begin
						cnt_q <= cnt_q - 4'h1;
					end
				end
				ST_STROBE: begin
					if (cnt_done) begin
						cnt_q <= 4'(RECOVER_CYC - 1);
						if (!is_write_q) begin
							owned_q <= !read_flag;
						end
					end else begin
						cnt_q <= cnt_q - 4'h1;
					end
				end
				ST_RECOVER: begin
					if (!cnt_done) begin
						cnt_q <= cnt_q - 4'h1;
					end
				end
				ST_DONE: begin
					cnt_q <= 4'(SETUP_CYC - 1);
					if (init_q) begin
						tok_q <= `TOKEN_IDX_W'(tok_q + 1'b1);
						if (last_token) begin
							init_q <= 1'b0;
						end
					end else if (read_after_q) begin
						is_write_q   <= 1'b0;
						read_after_q <= 1'b0;
					end else begin
						if (is_write_q && wdata_q) begin
							owned_q <= 1'b0;
						end
						rsp_q <= 1'b1;
					end
				end
			endcase
		end
	end

	a_no_chip_enable: assert property (@(posedge CLOCK) disable iff (RST)
		!FLAG_SPACE_SELECT_N |-> CHIP_ENABLE_N)
		else $error("Memory enable active during token access");
	a_write_one_bit: assert property (@(posedge CLOCK) disable iff (RST)
		!READ_WRITE_N |-> DATA_OE && DATA_OUT[`FLAG_BIT] == wdata_q)
		else $error("Write strobe without driven flag bit");
	a_poll_gap: assert property (@(posedge CLOCK) disable iff (RST)
		$rose(FLAG_SPACE_SELECT_N) |-> FLAG_SPACE_SELECT_N [*2])
		else $error("Select not released between accesses");
	a_claim_readback: assert property (@(posedge CLOCK) disable iff (RST)
		(cmd_take && CMD_OP == 2'(CMD_CLAIM)) |-> ##[1:40] (!OUT_ENABLE_N && READ_WRITE_N))
		else $error("Claim not followed by read-back");
	a_write_strobe: assert property (@(posedge CLOCK) disable iff (RST)
		$fell(READ_WRITE_N) |-> !READ_WRITE_N [*4] ##1 READ_WRITE_N)
		else $error("Write strobe length wrong");
	a_init_first: assert property (@(posedge CLOCK) disable iff (RST)
		init_q && !FLAG_SPACE_SELECT_N |-> DATA_OE && DATA_OUT[`FLAG_BIT] && !CMD_READY)
		else $error("Power-up access is not a write of one");
	a_oe_select: assert property (@(posedge CLOCK) disable iff (RST)
		!OUT_ENABLE_N |-> !FLAG_SPACE_SELECT_N && !DATA_OE)
		else $error("Output enable outside a token read");
	a_addr_low: assert property (@(posedge CLOCK) disable iff (RST)
		!FLAG_SPACE_SELECT_N && !$past(FLAG_SPACE_SELECT_N) |->
		$stable(TOKEN_INDEX_ADDR) && TOKEN_INDEX_ADDR[`ADDR_W-1:`TOKEN_IDX_W] == '0)
		else $error("Token address moved or upper lines driven");
endmodule
`default_nettype wire

// ===== hdl/token_host_regs.svh
// Timing counts and field positions for the token-flag host controller.
// Assumes a 200 MHz CLOCK; included by the host package users.
`ifndef TOKEN_HOST_REGS_SVH
`define TOKEN_HOST_REGS_SVH

`define CLK_PERIOD_NS     5
`define ACCESS_SETUP_NS   10
`define ACCESS_SETUP_CYC  ((`ACCESS_SETUP_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define STROBE_NS         20
`define STROBE_CYC        ((`STROBE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define RECOVER_NS        10
`define RECOVER_CYC       ((`RECOVER_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define TOKEN_COUNT       8
`define TOKEN_IDX_W       3
`define FLAG_BIT          0
`define DATA_W            16
`define ADDR_W            13

`endif

// ===== hdl/token_host_pkg.sv
// Types for the token-flag host controller.
// Counts and positions come from token_host_regs.svh.
package token_host_pkg;
	typedef enum {
		ST_IDLE,
		ST_SETUP,
		ST_STROBE,
		ST_RECOVER,
		ST_DONE
	} host_state_t;

	typedef enum logic [1:0] {
		CMD_CLAIM   = 2'h0,
		CMD_RELEASE = 2'h1,
		CMD_POLL    = 2'h2,
		CMD_INIT    = 2'h3
	} host_cmd_t;
endpackage

// ===== hdl/pin_sync.sv
// Two-stage synchroniser for a bus of pin inputs.
// Assumes the pins are asynchronous to CLOCK.
`timescale 1ns/10ps
`default_nettype none
module pin_sync #(
	parameter int W = 16
) (
	input  wire logic         clk,    // Local clock
	input  wire logic         rst,    // Asynchronous reset
	input  wire logic [W-1:0] d,      // Asynchronous pins
	output logic      [W-1:0] q       // Synchronised value
);
	logic [W-1:0] meta_q;

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			meta_q <= '0;
			q      <= '0;
		end else begin
			meta_q <= d;
			q      <= meta_q;
		end
	end
endmodule
`default_nettype wire

// ===== bench/token_flags_model.sv
// Two-port token-flag device model, one port per side.
// Assumes active-low selects; a write lands at the rising write strobe.
`timescale 1ns/10ps
`default_nettype none
module token_flags_model (
	input  wire logic [12:0] a_addr,  // Side A address
	input  wire logic        a_ce_n,  // Side A memory enable
	input  wire logic        a_sel_n, // Side A token select
	input  wire logic        a_oe_n,  // Side A output enable
	input  wire logic        a_rw_n,  // Side A read/write
	input  wire logic [15:0] a_din,   // Side A write data
	output logic      [15:0] a_dout,  // Side A read data
	input  wire logic [12:0] b_addr,  // Side B address
	input  wire logic        b_sel_n, // Side B token select
	input  wire logic        b_oe_n,  // Side B output enable
	input  wire logic        b_rw_n,  // Side B read/write
	input  wire logic [15:0] b_din,   // Side B write data
	output logic      [15:0] b_dout   // Side B read data
);
	logic [7:0] req_a;
	logic [7:0] req_b;
	logic [1:0] own [8]; // 0 free, 1 side A, 2 side B
	logic       lat_a;
	logic       lat_b;
	function automatic logic view(logic [1:0] s, logic [2:0] i);
		return own[i] != s;
	endfunction
	task automatic put(logic [1:0] s, logic [2:0] i, logic v);
		if (s == 2'h1) req_a[i] = v;
		else req_b[i] = v;
		if (own[i] == 2'h0 && !v) own[i] = s;
		else if (own[i] == s && v) own[i] = ((s == 2'h1) ? req_b[i] : req_a[i]) ? 2'h0 : 2'h3 - s;
	endtask
	// Writes use only bit zero and the three low address lines; no array is modelled
	always @(posedge a_rw_n) if (!a_sel_n && a_ce_n) put(2'h1, a_addr[2:0], a_din[0]);
	always @(posedge b_rw_n) if (!b_sel_n) put(2'h2, b_addr[2:0], b_din[0]);
	always @(negedge (a_sel_n | a_oe_n)) lat_a = view(2'h1, a_addr[2:0]);
	always @(negedge (b_sel_n | b_oe_n)) lat_b = view(2'h2, b_addr[2:0]);
	// Released bus shows the inverse so a stale value cannot pass
	assign a_dout = (!a_sel_n && !a_oe_n && a_rw_n) ? {16{lat_a}} : {16{~lat_a}};
	assign b_dout = (!b_sel_n && !b_oe_n && b_rw_n) ? {16{lat_b}} : {16{~lat_b}};
	initial begin
		req_a = 8'ha5; // Leftover requests at power-up
		req_b = 8'hff;
		foreach (own[i]) own[i] = req_a[i] ? 2'h0 : 2'h1;
		lat_a = 1'b1;
		lat_b = 1'b1;
	end
endmodule
`default_nettype wire

// ===== bench/tb_token_host.sv
// Self-checking bench for token_host against the token-flag model.
// Assumes side B of the model is driven directly by this bench.
`timescale 1ns/10ps
`default_nettype none
`define CHK(nm, ex, gt) begin total_checks++; if ((gt) !== (ex)) begin fail_count++; \
	$display("[ERR] %s exp %h got %h", nm, ex, gt); end end
module tb_token_host;
	import token_host_pkg::*;
	logic        CLOCK, RST, cmd_valid, cmd_ready, rsp_valid, rsp_owned, init_busy;
	logic [1:0]  cmd_op;
	logic [2:0]  cmd_token, t;
	logic [12:0] a_addr, b_addr;
	logic        ce_n, sel_n, oe_n, rw_n, data_oe, b_sel_n, b_oe_n, b_rw_n;
	logic [15:0] data_out, a_dout, b_dout, b_din;
	wire  [15:0] data_pins = data_oe ? data_out : a_dout;
	int          fail_count, total_checks;
	token_host token_host_inst (.CLOCK(CLOCK), .RST(RST), .CMD_VALID(cmd_valid), .CMD_READY(cmd_ready),
		.CMD_OP(cmd_op), .CMD_TOKEN(cmd_token), .RSP_VALID(rsp_valid), .RSP_OWNED(rsp_owned),
		.INIT_BUSY(init_busy), .TOKEN_INDEX_ADDR(a_addr), .CHIP_ENABLE_N(ce_n), .FLAG_SPACE_SELECT_N(sel_n),
		.OUT_ENABLE_N(oe_n), .READ_WRITE_N(rw_n), .DATA_IN(data_pins), .DATA_OUT(data_out), .DATA_OE(data_oe));
	token_flags_model token_flags_model_inst (.a_addr(a_addr), .a_ce_n(ce_n), .a_sel_n(sel_n), .a_oe_n(oe_n),
		.a_rw_n(rw_n), .a_din(data_out), .a_dout(a_dout), .b_addr(b_addr), .b_sel_n(b_sel_n),
		.b_oe_n(b_oe_n), .b_rw_n(b_rw_n), .b_din(b_din), .b_dout(b_dout));
	always #2.5 CLOCK = ~CLOCK;
	task automatic final_report();
		$display("checks %0d mismatches %0d", total_checks, fail_count);
		if (fail_count == 0 && total_checks > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask
	task automatic host(logic [1:0] op, logic [2:0] tk, logic ex);
		int n;
		n = 0;
		while (cmd_ready !== 1'b1 && n < 300) begin
			@(negedge CLOCK);
			n++;
		end
		cmd_op = op;
		cmd_token = tk;
		cmd_valid = 1'b1;
		@(negedge CLOCK);
		cmd_valid = 1'b0;
		while (rsp_valid !== 1'b1 && n < 300) begin
			@(negedge CLOCK);
			n++;
		end
		if (n >= 300) begin
			fail_count++;
			final_report();
		end else begin
			`CHK("rsp_owned", ex, rsp_owned)
			`CHK("chip_enable_n", 1'b1, ce_n)
		end
	endtask
	task automatic bwr(logic [2:0] tk, logic v);
		b_addr = {10'($urandom), tk};
		b_din = {15'($urandom), v};
		b_sel_n = 1'b0;
		@(negedge CLOCK);
		b_rw_n = 1'b0;
		repeat (4) @(negedge CLOCK);
		b_rw_n = 1'b1;
		@(negedge CLOCK);
		b_sel_n = 1'b1;
		@(negedge CLOCK);
	endtask
	task automatic brd(logic [2:0] tk, logic v);
		b_addr = {10'($urandom), tk};
		b_sel_n = 1'b0;
		b_oe_n = 1'b0;
		@(negedge CLOCK);
		`CHK("side_b_flag", {16{v}}, b_dout)
		b_sel_n = 1'b1;
		b_oe_n = 1'b1;
		@(negedge CLOCK);
	endtask
	initial begin
		CLOCK = 1'b0;
		RST = 1'b1;
		{cmd_valid, cmd_op, cmd_token, b_addr, b_din} = '0;
		{b_sel_n, b_oe_n, b_rw_n} = 3'h7;
		fail_count = 0;
		total_checks = 0;
		void'($urandom(28));
		repeat (3) @(negedge CLOCK);
		RST = 1'b0;
		@(negedge CLOCK);
		`CHK("cmd_ready", 1'b0, cmd_ready)
		`CHK("init_busy", 1'b1, init_busy)
		for (int i = 0; i < 8; i++) bwr(3'(i), 1'b1);
		host(CMD_POLL, 3'h1, 1'b0);
		`CHK("init_busy", 1'b0, init_busy)
		for (int i = 0; i < 8; i++) brd(3'(i), 1'b1);
		repeat (6) begin
			t = 3'($urandom % 8);
			host(CMD_CLAIM, t, 1'b1);
			bwr(t, 1'b0);
			brd(t, 1'b1);
			host(CMD_POLL, t, 1'b1);
			host($urandom % 2 ? CMD_RELEASE : CMD_INIT, t, 1'b0);
			brd(t, 1'b0);
			host(CMD_CLAIM, t, 1'b0);
			bwr(t, 1'b1);
			brd(t, 1'b1);
			host(CMD_POLL, t, 1'b1);
			host(CMD_RELEASE, t, 1'b0);
			brd(t, 1'b1);
		end
		final_report();
	end
endmodule
`default_nettype wire
